// ===== rtl/fcic_pkg.sv
// Shared constants, field positions and carrier types of the filter interrupt and start block.
package fcic_pkg;

    // Register byte offsets on the Wishbone bus.
    localparam logic [7:0] OFS_CTRL_STATUS = 8'h00;
    localparam logic [7:0] OFS_TAP_COUNT   = 8'h04;
    localparam logic [7:0] OFS_SAMPLE_IN   = 8'h08;
    localparam logic [7:0] OFS_SAMPLE_OUT  = 8'h0C;
    localparam logic [7:0] OFS_PRIORITY    = 8'h10;
    localparam logic [7:0] OFS_IRQ_STATUS  = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK    = 8'h18;

    // Bit positions inside the control/status register.
    localparam int CTRL_IN_EMPTY_BIT  = 0;
    localparam int CTRL_OUT_FULL_BIT  = 1;
    localparam int CTRL_MODE_BIT      = 2;
    localparam int CTRL_IN_IRQ_EN_BIT = 10;
    localparam int CTRL_OUT_IRQ_EN_BIT = 11;

    // Bit positions of the two priority bits; bit a is the level's high bit.
    localparam int PRIO_BIT_A = 10;
    localparam int PRIO_BIT_B = 11;

    // Sticky event bits in the interrupt status and mask registers.
    localparam int EVT_IN_EMPTY = 0;
    localparam int EVT_OUT_FULL = 1;
    localparam int EVT_W        = 2;

    // Source numbers and vector offsets of the two data transfer requests.
    localparam logic [6:0] SRC_IN_EMPTY  = 7'h34;
    localparam logic [6:0] SRC_OUT_FULL  = 7'h35;
    localparam logic [7:0] VEC_IN_EMPTY  = 8'h68;
    localparam logic [7:0] VEC_OUT_FULL  = 8'h6A;

    // Reset values.
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
    localparam logic [31:0] PRIO_RESET      = 32'h0000_0000;
    localparam logic [31:0] TAP_COUNT_RESET = 32'h0000_0001;
    localparam logic [31:0] BUS_ZERO        = 32'h0000_0000;

    // One vectored request toward the core's interrupt logic.
    typedef struct packed {
        logic       req;
        logic [6:0] source;
        logic [7:0] vector;
        logic [1:0] level;
    } fcic_irq_s;

    // Sample engine states.
    typedef enum {ST_IDLE, ST_ACC, ST_OUT} fcic_state_e;

    // Merges write data into an old word under the Wishbone byte selects.
    function automatic logic [31:0] fcic_merge(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  sel);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = new_w[8*b +: 8];
            end
        end
        return res;
    endfunction

endpackage

// ===== rtl/fcic_irq_req.sv
// One vectored data transfer request: flag gated by its enable, tagged with source and level.
`timescale 1ns/1ns
module fcic_irq_req #(
    parameter logic [6:0] SOURCE = 7'h00,
    parameter logic [7:0] VECTOR = 8'h00
) (
    input  wire logic              flag_i,
    input  wire logic              en_i,
    input  wire logic [1:0]        level_i,
    output fcic_pkg::fcic_irq_s    irq_o
);

    // The request is a pure level: it stands while flag and enable both stand, so it
    // drops by itself once the host services the data register.
    always_comb begin
        irq_o.req    = flag_i & en_i;
        irq_o.source = SOURCE;
        irq_o.vector = VECTOR;
        irq_o.level  = level_i;
    end

endmodule

// ===== rtl/fcic_accum.sv
// Sequential tap accumulator: sums count_i samples, one per clock, newest first.
`timescale 1ns/1ns
module fcic_accum #(
    parameter int DW = 24,
    parameter int AW = 6
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          start_i,
    input  wire logic [AW:0]   count_i,
    input  wire logic [DW-1:0] data_i,
    output logic      [AW:0]   idx_o,
    output logic               done_o,
    output logic      [DW-1:0] sum_o
);

    logic          busy_reg;   // High while taps are being summed.
    logic [DW-1:0] acc_reg;    // Running sum; wraps, since coefficients are outside.

    // One tap per cycle keeps the memory to a single read port at the cost of latency.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_reg <= 1'b0;
            idx_o    <= '0;
            acc_reg  <= '0;
            done_o   <= 1'b0;
            sum_o    <= '0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                busy_reg <= 1'b1;
                idx_o    <= '0;
                acc_reg  <= '0;
            end else if (busy_reg) begin
                acc_reg <= acc_reg + data_i;
                idx_o   <= idx_o + 1'b1;
                // Last tap reached: publish the sum for one cycle.
                if (idx_o == count_i - 1'b1) begin
                    busy_reg <= 1'b0;
                    done_o   <= 1'b1;
                    sum_o    <= acc_reg + data_i;
                end
            end
        end
    end

endmodule

// ===== rtl/fcic_top.sv
// Filter coprocessor data transfer requests, start control and register slave.
`timescale 1ns/1ns
module fcic_top #(
    parameter int DW    = 24,
    parameter int DEPTH = 64
) (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            wb_cyc_i,
    input  wire logic            wb_stb_i,
    input  wire logic            wb_we_i,
    input  wire logic [7:0]      wb_adr_i,
    input  wire logic [3:0]      wb_sel_i,
    input  wire logic [31:0]     wb_dat_i,
    output logic      [31:0]     wb_dat_o,
    output logic                 wb_ack_o,
    output fcic_pkg::fcic_irq_s  in_irq_o,
    output fcic_pkg::fcic_irq_s  out_irq_o,
    output logic                 dma_in_req_o,
    output logic                 dma_out_req_o,
    output logic                 irq_o
);

    localparam int AW = $clog2(DEPTH);

    logic [31:0]               filter_ctrl_status_reg; // Mode and enables; flags overlay.
    logic [31:0]               periph_priority_reg;    // Priority field at bits 10 and 11.
    logic [AW:0]               tap_count_reg;          // Taps, held within 1..DEPTH.
    logic [DW-1:0]             sample_in_reg;          // Sample waiting for the engine.
    logic [DW-1:0]             sample_out_reg;         // Last computed output.
    logic                      in_full_reg;            // Input register holds a sample.
    logic                      out_full_reg;           // Output register not yet read.
    logic [fcic_pkg::EVT_W-1:0] irq_status_reg;        // Sticky events.
    logic [fcic_pkg::EVT_W-1:0] irq_mask_reg;          // Event enables for irq_o.
    logic [DW-1:0]             filter_sample_memory [DEPTH]; // Sample history ring.
    logic [AW-1:0]             wr_ptr_reg;             // Next free slot of the ring.
    logic [AW:0]               fill_cnt_reg;           // Samples stored, saturating.
    logic [DW-1:0]             result_reg;             // Sum waiting for output room.
    logic                      start_reg;              // One-cycle accumulator start.
    fcic_pkg::fcic_state_e     state_reg;

    logic            bus_req;
    logic            wr_fire;
    logic            rd_fire;
    logic            take;
    logic            go;
    logic            load_out;
    logic [AW:0]     fill_next;
    logic [AW:0]     acc_idx;
    logic            acc_done;
    logic [DW-1:0]   acc_sum;
    logic [AW-1:0]   rd_addr;
    logic            input_buf_empty_flag;
    logic            output_buf_full_flag;
    logic            start_mode_select;
    logic            input_empty_irq_en;
    logic            output_full_irq_en;
    logic [1:0]      irq_level;

    // Keeps a software tap count within what the memory can hold.
    function automatic logic [AW:0] clamp_taps(input logic [31:0] v);
        if (v == 32'h0000_0000) begin
            return (AW+1)'(1);
        end else if (v > DEPTH) begin
            return (AW+1)'(DEPTH);
        end else begin
            return v[AW:0];
        end
    endfunction

    // Field views of the control and priority registers.
    assign input_buf_empty_flag = ~in_full_reg;
    assign output_buf_full_flag = out_full_reg;
    assign start_mode_select    = filter_ctrl_status_reg[fcic_pkg::CTRL_MODE_BIT];
    assign input_empty_irq_en   = filter_ctrl_status_reg[fcic_pkg::CTRL_IN_IRQ_EN_BIT];
    assign output_full_irq_en   = filter_ctrl_status_reg[fcic_pkg::CTRL_OUT_IRQ_EN_BIT];
    // Bit a is the high bit: 00 -> level 0 up to 11 -> level 3.
    assign irq_level = {periph_priority_reg[fcic_pkg::PRIO_BIT_A],
                        periph_priority_reg[fcic_pkg::PRIO_BIT_B]};

    // Wishbone: ack comes one cycle after the request; effects land on the ack edge.
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign wr_fire = bus_req & wb_ack_o & wb_we_i;
    assign rd_fire = bus_req & wb_ack_o & ~wb_we_i;

    // Registered ack; it drops in the cycle after it was given.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
        end
    end

    // Read data is captured as the ack rises; unmapped offsets read zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= fcic_pkg::BUS_ZERO;
        end else if (bus_req & ~wb_ack_o) begin
            case (wb_adr_i)
                fcic_pkg::OFS_CTRL_STATUS: begin
                    wb_dat_o <= filter_ctrl_status_reg;
                    wb_dat_o[fcic_pkg::CTRL_IN_EMPTY_BIT] <= input_buf_empty_flag;
                    wb_dat_o[fcic_pkg::CTRL_OUT_FULL_BIT] <= output_buf_full_flag;
                end
                fcic_pkg::OFS_TAP_COUNT:  wb_dat_o <= 32'(tap_count_reg);
                fcic_pkg::OFS_SAMPLE_IN:  wb_dat_o <= 32'(sample_in_reg);
                fcic_pkg::OFS_SAMPLE_OUT: wb_dat_o <= 32'(sample_out_reg);
                fcic_pkg::OFS_PRIORITY:   wb_dat_o <= periph_priority_reg;
                fcic_pkg::OFS_IRQ_STATUS: wb_dat_o <= 32'(irq_status_reg);
                fcic_pkg::OFS_IRQ_MASK:   wb_dat_o <= 32'(irq_mask_reg);
                default:                  wb_dat_o <= fcic_pkg::BUS_ZERO;
            endcase
        end
    end

    // Configuration registers; the two flag bits are read-only overlays.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            filter_ctrl_status_reg <= fcic_pkg::CTRL_RESET;
            periph_priority_reg    <= fcic_pkg::PRIO_RESET;
            tap_count_reg          <= clamp_taps(fcic_pkg::TAP_COUNT_RESET);
            irq_mask_reg           <= '0;
        end else if (wr_fire) begin
            case (wb_adr_i)
                fcic_pkg::OFS_CTRL_STATUS: begin
                    filter_ctrl_status_reg <= fcic_pkg::fcic_merge(filter_ctrl_status_reg,
                                                                   wb_dat_i, wb_sel_i);
                end
                fcic_pkg::OFS_PRIORITY: begin
                    periph_priority_reg <= fcic_pkg::fcic_merge(periph_priority_reg,
                                                                wb_dat_i, wb_sel_i);
                end
                fcic_pkg::OFS_TAP_COUNT: begin
                    tap_count_reg <= clamp_taps(fcic_pkg::fcic_merge(32'(tap_count_reg),
                                                                     wb_dat_i, wb_sel_i));
                end
                fcic_pkg::OFS_IRQ_MASK: begin
                    irq_mask_reg <= wb_dat_i[fcic_pkg::EVT_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Engine handshakes with the two data registers.
    assign take      = (state_reg == fcic_pkg::ST_IDLE) & in_full_reg;
    assign fill_next = (fill_cnt_reg >= tap_count_reg) ? fill_cnt_reg : fill_cnt_reg + 1'b1;
    // Mode set starts at once; mode clear waits until tap_count samples are stored.
    assign go        = start_mode_select | (fill_next >= tap_count_reg);
    assign load_out  = (state_reg == fcic_pkg::ST_OUT) & ~out_full_reg;

    // Input register: a bus write fills it, the engine empties it.
    // A write while full overwrites the pending sample, as on a one-deep register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_full_reg   <= 1'b0;
            sample_in_reg <= '0;
        end else if (wr_fire & (wb_adr_i == fcic_pkg::OFS_SAMPLE_IN)) begin
            in_full_reg   <= 1'b1;
            sample_in_reg <= wb_dat_i[DW-1:0];
        end else if (take) begin
            in_full_reg <= 1'b0;
        end
    end

    // Output register: the engine fills it, a bus read empties it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_full_reg   <= 1'b0;
            sample_out_reg <= '0;
        end else if (load_out) begin
            out_full_reg   <= 1'b1;
            sample_out_reg <= result_reg;
        end else if (rd_fire & (wb_adr_i == fcic_pkg::OFS_SAMPLE_OUT)) begin
            out_full_reg <= 1'b0;
        end
    end

    // Sample history; no reset, so stale contents remain until new samples overwrite them.
    always_ff @(posedge clk_i) begin
        if (take) begin
            filter_sample_memory[wr_ptr_reg] <= sample_in_reg;
        end
    end

    // Sample engine: store, count, accumulate, then wait for room in the output.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg    <= fcic_pkg::ST_IDLE;
            wr_ptr_reg   <= '0;
            fill_cnt_reg <= '0;
            start_reg    <= 1'b0;
            result_reg   <= '0;
        end else begin
            start_reg <= 1'b0;
            // Rewriting the control register restarts the fill count for a new run.
            if (wr_fire & (wb_adr_i == fcic_pkg::OFS_CTRL_STATUS)) begin
                fill_cnt_reg <= '0;
            end else if (take) begin
                fill_cnt_reg <= fill_next;
            end
            case (state_reg)
                fcic_pkg::ST_IDLE: begin
                    if (take) begin
                        wr_ptr_reg <= wr_ptr_reg + 1'b1;
                        if (go) begin
                            start_reg <= 1'b1;
                            state_reg <= fcic_pkg::ST_ACC;
                        end
                    end
                end
                fcic_pkg::ST_ACC: begin
                    if (acc_done) begin
                        result_reg <= acc_sum;
                        state_reg  <= fcic_pkg::ST_OUT;
                    end
                end
                fcic_pkg::ST_OUT: begin
                    if (load_out) begin
                        state_reg <= fcic_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= fcic_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Newest sample sits just behind the write pointer; taps walk backwards.
    assign rd_addr = wr_ptr_reg - 1'b1 - acc_idx[AW-1:0];

    fcic_accum #(
        .DW (DW),
        .AW (AW)
    ) u_accum (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (start_reg),
        .count_i (tap_count_reg),
        .data_i  (filter_sample_memory[rd_addr]),
        .idx_o   (acc_idx),
        .done_o  (acc_done),
        .sum_o   (acc_sum)
    );

    // Sticky events: the empty event on every take, the full event on every load.
    // Set wins over a same-cycle write-one-to-clear so no event is lost.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_status_reg <= '0;
        end else begin
            for (int i = 0; i < fcic_pkg::EVT_W; i++) begin
                if ((i == fcic_pkg::EVT_IN_EMPTY && take) ||
                    (i == fcic_pkg::EVT_OUT_FULL && load_out)) begin
                    irq_status_reg[i] <= 1'b1;
                end else if (wr_fire & (wb_adr_i == fcic_pkg::OFS_IRQ_STATUS) &
                             wb_sel_i[0] & wb_dat_i[i]) begin
                    irq_status_reg[i] <= 1'b0;
                end
            end
        end
    end

    assign irq_o = |(irq_status_reg & irq_mask_reg);

    // DMA requests follow the flags regardless of the interrupt enables.
    assign dma_in_req_o  = input_buf_empty_flag;
    assign dma_out_req_o = output_buf_full_flag;

    fcic_irq_req #(
        .SOURCE (fcic_pkg::SRC_IN_EMPTY),
        .VECTOR (fcic_pkg::VEC_IN_EMPTY)
    ) u_in_irq (
        .flag_i  (input_buf_empty_flag),
        .en_i    (input_empty_irq_en),
        .level_i (irq_level),
        .irq_o   (in_irq_o)
    );

    fcic_irq_req #(
        .SOURCE (fcic_pkg::SRC_OUT_FULL),
        .VECTOR (fcic_pkg::VEC_OUT_FULL)
    ) u_out_irq (
        .flag_i  (output_buf_full_flag),
        .en_i    (output_full_irq_en),
        .level_i (irq_level),
        .irq_o   (out_irq_o)
    );

    // Checks on the request outputs, the start decision and the DMA lines.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence seq_sample_taken;
        take;
    endsequence

    sequence seq_acc_started;
        start_reg ##1 (state_reg == fcic_pkg::ST_ACC);
    endsequence

    chk_in_irq_raise: assert property ($rose(~in_full_reg) && input_empty_irq_en
        |-> in_irq_o.req && in_irq_o.vector == 8'h68)
        else $error("Input empty request missing.");
    chk_out_irq_raise: assert property ($rose(out_full_reg) && output_full_irq_en
        |-> out_irq_o.req && out_irq_o.vector == 8'h6A)
        else $error("Output full request missing.");
    chk_irq_no_enable: assert property (!output_full_irq_en |-> !out_irq_o.req
        && (input_empty_irq_en || !in_irq_o.req))
        else $error("Request raised without enable.");
    chk_in_irq_source: assert property (in_irq_o.req |-> in_irq_o.source == 7'd52)
        else $error("Input request source wrong.");
    chk_out_irq_source: assert property (out_irq_o.req |-> out_irq_o.source == 7'd53)
        else $error("Output request source wrong.");
    chk_irq_level_map: assert property (in_irq_o.level
        == {periph_priority_reg[10], periph_priority_reg[11]})
        else $error("Request level does not follow priority.");
    chk_defer_until_full: assert property (start_reg && !start_mode_select
        |-> fill_cnt_reg >= tap_count_reg)
        else $error("Filtering started before memory filled.");
    chk_start_first_sample: assert property (start_mode_select && state_reg ==
        fcic_pkg::ST_IDLE ##0 seq_sample_taken |=> seq_acc_started)
        else $error("Filtering did not start on sample.");
    chk_count_no_start: assert property (take && !start_mode_select
        && fill_next < tap_count_reg |=> !start_reg)
        else $error("Calculation began before tap count reached.");
    chk_dma_follow: assert property (dma_in_req_o == !in_full_reg
        && dma_out_req_o == out_full_reg)
        else $error("DMA request does not follow flag.");
    chk_irq_hold: assert property (in_irq_o.req && input_empty_irq_en && !in_full_reg
        ##1 input_empty_irq_en && !in_full_reg |-> in_irq_o.req)
        else $error("Request dropped while flag and enable stand.");

endmodule

// ===== test/fcic_core_model.sv
// Behavioural model of the host core's interrupt acceptance and vector slot lookup.
`timescale 1ns/1ns
module fcic_core_model (
    input  wire fcic_pkg::fcic_irq_s in_irq_i,
    input  wire fcic_pkg::fcic_irq_s out_irq_i,
    input  wire logic [1:0]          sr_mask_i,
    input  wire logic [15:0]         vector_base_i,
    output logic                     take_in_o,
    output logic                     take_out_o,
    output logic [15:0]              in_addr_o,
    output logic [15:0]              out_addr_o
);
    // The core admits a request only at or above its mask level.
    assign take_in_o  = in_irq_i.req && (in_irq_i.level >= sr_mask_i);
    assign take_out_o = out_irq_i.req && (out_irq_i.level >= sr_mask_i);
    // Slots sit two words apart, so the slot is found from the source alone.
    // This ties the vector a request carries to its source number.
    assign in_addr_o  = vector_base_i + {8'h00, in_irq_i.source, 1'b0};
    assign out_addr_o = vector_base_i + {8'h00, out_irq_i.source, 1'b0};
endmodule

// ===== test/tb.sv
// Self-checking bench for the filter interrupt request and start block.
`timescale 1ns/1ns
module tb;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
    logic        wb_ack_o, dma_in_req_o, dma_out_req_o, irq_o, take_in, take_out;
    logic [1:0]  sr_mask = 2'b10; // Core mask admits levels two and three.
    logic [15:0] in_addr, out_addr;
    fcic_pkg::fcic_irq_s in_irq_o, out_irq_o;
    int          err_count = 0, samples_checked = 0, cycles = 0;
    fcic_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .in_irq_o(in_irq_o),
        .out_irq_o(out_irq_o), .dma_in_req_o(dma_in_req_o),
        .dma_out_req_o(dma_out_req_o), .irq_o(irq_o));
    fcic_core_model core (.in_irq_i(in_irq_o), .out_irq_i(out_irq_o), .sr_mask_i(sr_mask),
        .vector_base_i(16'h0100), .take_in_o(take_in), .take_out_o(take_out),
        .in_addr_o(in_addr), .out_addr_o(out_addr));
    // Free running clock at 8 ns.
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    // Hang guard; the whole run needs well under a thousand cycles.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            final_report();
        end
    end
    // Compares one word and counts it.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One classic Wishbone cycle; the request stands until ack is sampled.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Waits a bounded time for the output register to fill.
    task automatic wait_full();
        for (int n = 0; n < 200 && dma_out_req_o !== 1'b1; n++) @(posedge clk_i);
    endtask
    // Reset state: input empty requests transfer, nothing else requested.
    task automatic t_reset();
        wb(1'b0, fcic_pkg::OFS_CTRL_STATUS, 32'h0000_0000);
        chk(q, 32'h0000_0001);
        chk({dma_in_req_o, dma_out_req_o, in_irq_o.req, irq_o}, 32'h0000_0008);
        wb(1'b0, 8'hFC, 32'h0000_0000);
        chk(q, 32'h0000_0000);
    endtask
    // Input enable raises the request; every priority code reaches the core.
    task automatic t_prio();
        wb(1'b1, fcic_pkg::OFS_CTRL_STATUS, 32'h0000_0400);
        chk(in_irq_o.req, 32'h0000_0001);
        chk(in_addr, 32'h0000_0168);
        chk(in_irq_o.vector, 32'h0000_0068);
        for (int lv = 0; lv < 4; lv++) begin
            // Bit ten carries the high bit of the level.
            wb(1'b1, fcic_pkg::OFS_PRIORITY, {20'h0_0000, lv[0], lv[1], 10'h000});
            chk(in_irq_o.level, lv);
            chk(take_in, (lv >= 2));
        end
        wb(1'b1, fcic_pkg::OFS_CTRL_STATUS, 32'h0000_0000);
        chk(in_irq_o.req, 32'h0000_0000);
    endtask
    // Start on first sample: three taps, yet one sample yields an output.
    // The previous scenario left known samples in memory, so nothing stale feeds the sum.
    task automatic t_mode1();
        wb(1'b1, fcic_pkg::OFS_TAP_COUNT, 32'h0000_0003);
        wb(1'b1, fcic_pkg::OFS_CTRL_STATUS, 32'h0000_0804);
        wb(1'b1, fcic_pkg::OFS_SAMPLE_IN, 32'h0000_0055);
        wait_full();
        chk(dma_out_req_o, 32'h0000_0001);
        chk({out_irq_o.req, in_irq_o.req}, 32'h0000_0002);
        chk(out_addr, 32'h0000_016A);
        chk(out_irq_o.vector, 32'h0000_006A);
        chk(out_irq_o.level, 32'h0000_0003);
        chk(take_out, 32'h0000_0001);
        wb(1'b1, fcic_pkg::OFS_IRQ_MASK, 32'h0000_0002);
        chk(irq_o, 32'h0000_0001);
        wb(1'b1, fcic_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
        chk(irq_o, 32'h0000_0000);
        // Newest three slots hold 55h, 40h and 20h, so the sum uses memory as found.
        wb(1'b0, fcic_pkg::OFS_SAMPLE_OUT, 32'h0000_0000);
        chk(q, 32'h0000_00B5);
        chk({out_irq_o.req, dma_out_req_o}, 32'h0000_0000);
    endtask
    // Wait-until-full mode: no output until the third sample.
    task automatic t_mode0();
        wb(1'b1, fcic_pkg::OFS_TAP_COUNT, 32'h0000_0003);
        wb(1'b1, fcic_pkg::OFS_CTRL_STATUS, 32'h0000_0800);
        wb(1'b1, fcic_pkg::OFS_SAMPLE_IN, 32'h0000_0010);
        wb(1'b1, fcic_pkg::OFS_SAMPLE_IN, 32'h0000_0020);
        repeat (20) @(posedge clk_i);
        chk(dma_out_req_o, 32'h0000_0000);
        wb(1'b1, fcic_pkg::OFS_SAMPLE_IN, 32'h0000_0040);
        wait_full();
        chk(out_irq_o.req, 32'h0000_0001);
        wb(1'b0, fcic_pkg::OFS_SAMPLE_OUT, 32'h0000_0000);
        chk(q, 32'h0000_0070);
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Main sequence.
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_prio();
        t_mode0();
        t_mode1();
        final_report();
    end
endmodule
